// ===== hdl/arith_unit_defines.vh
`ifndef ARITH_UNIT_DEFINES_VH
`define ARITH_UNIT_DEFINES_VH

// Processing cycle and clock rate.
`define CYCLE_TIME_US 20000
`define CLK_RATE_MHZ 10
`define CYCLE_CLKS (`CYCLE_TIME_US * `CLK_RATE_MHZ)

// Register byte offsets.
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IN_BASE 12'h010
`define OFS_CALC_CFG 12'h020
`define OFS_CALC_UPPER 12'h024
`define OFS_CALC_LOWER 12'h028
`define OFS_FILT_CFG 12'h030
`define OFS_FILT_PARAM 12'h034
`define OFS_DI_CFG 12'h040
`define OFS_DI_F1 12'h044
`define OFS_DI_F2 12'h048
`define OFS_DI_UPPER 12'h04c
`define OFS_DI_LOWER 12'h050
`define OFS_CMP_CFG 12'h060
`define OFS_POOL_BASE 12'h080

// Signal pool slots written by the blocks.
`define SLOT_CALC 3'h4
`define SLOT_FILT 3'h5
`define SLOT_DI 3'h6
`define SLOT_CMP 3'h7

// Field positions.
`define CTRL_RUN 0
`define CTRL_TRIG 1
`define CALC_OP 16
`define CALC_STAGE_LSB 20
`define FILT_TYPE 4
`define FILT_STAGE_LSB 8
`define DI_TYPE 8
`define DI_STAGE_LSB 12
`define DI_TB_LSB 16
`define CMP_TYPE_LSB 16
`define CMP_STAGE_LSB 20

// Type codes.
`define CMP_GT 2'h0
`define CMP_GE 2'h1
`define CMP_EQ 2'h2

// Reset values.
`define RST_CFG 32'h0000_0000
`define RST_UPPER 32'h7fff_ffff
`define RST_LOWER 32'h8000_0000
`define RST_ONE 32'h0000_0001

`endif

// ===== hdl/arithmetic_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "arith_unit_defines.vh"

module arithmetic_unit #(
    parameter CYCLE_CLKS = `CYCLE_CLKS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg calc_div_zero_flag,
    output reg cycle_busy
);

localparam ST_IDLE = 1'b0;
localparam ST_RUN = 1'b1;

////////////////////////////////////////////////////////////////////////////////

function signed [31:0] sdiv;
    input signed [31:0] n;
    input signed [31:0] d;
    begin
        sdiv = (d == 32'sh0) ? 32'sh0 : n / d;
    end
endfunction

function signed [31:0] clamp;
    input signed [31:0] v;
    input signed [31:0] hi;
    input signed [31:0] lo;
    begin
        if (v > hi) begin
            clamp = hi;
        end else if (v < lo) begin
            clamp = lo;
        end else begin
            clamp = v;
        end
    end
endfunction

// Operands are the low 16 bits of a pool word, sign extended.
function signed [31:0] op16;
    input [31:0] w;
    begin
        op16 = {{16{w[15]}}, w[15:0]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg run_reg;
reg trig_reg;
reg [15:0] in_reg [0:3];
reg [31:0] calc_cfg_reg, calc_upper_reg, calc_lower_reg;
reg [31:0] filt_cfg_reg, filt_param_reg;
reg [31:0] di_cfg_reg, di_f1_reg, di_f2_reg, di_upper_reg, di_lower_reg;
reg [31:0] cmp_cfg_reg;
reg [31:0] pool_reg [0:7];
reg [31:0] di_prev_reg;
reg [15:0] tb_cnt_reg;
reg [17:0] tick_cnt_reg;
reg state_reg;
reg [3:0] step_reg;
reg [31:0] rd_next;
reg err_next;
integer i, j;

wire apb_wr = psel & penable & pready & pwrite;
wire apb_setup = psel & ~penable;
wire tick = (tick_cnt_reg == CYCLE_CLKS[17:0] - 18'h1);
wire start = (state_reg == ST_IDLE) & ((tick & run_reg) | trig_reg);
wire [1:0] cur_stage = step_reg[3:2];
wire [1:0] cur_block = step_reg[1:0];

////////////////////////////////////////////////////////////////////////////////
// Block datapaths, evaluated from the current pool contents.

wire signed [31:0] ca = op16(pool_reg[calc_cfg_reg[2:0]]);
wire signed [31:0] cm1 = op16(pool_reg[calc_cfg_reg[6:4]]);
wire signed [31:0] cm2 = op16(pool_reg[calc_cfg_reg[10:8]]);
wire signed [31:0] cb = op16(pool_reg[calc_cfg_reg[14:12]]);
wire calc_zero = (cm2 == 32'sh0);
wire signed [31:0] calc_q = sdiv(ca * cm1, cm2);
wire signed [31:0] calc_raw = calc_cfg_reg[`CALC_OP] ? calc_q - cb : calc_q + cb;
wire signed [31:0] calc_val = calc_zero ? 32'sh0 :
    clamp(calc_raw, calc_upper_reg, calc_lower_reg);

wire signed [31:0] f_in = op16(pool_reg[filt_cfg_reg[2:0]]);
wire signed [31:0] f_prev = pool_reg[`SLOT_FILT];
wire signed [31:0] f_n = filt_param_reg;
wire signed [31:0] f_mean = sdiv((f_n - 32'sh1) * f_prev + f_in, f_n);
wire signed [31:0] f_up = f_prev + f_n;
wire signed [31:0] f_dn = f_prev - f_n;
wire signed [31:0] f_ramp = (f_in > f_up) ? f_up : (f_in < f_dn) ? f_dn : f_in;
wire signed [31:0] filt_val = filt_cfg_reg[`FILT_TYPE] ? f_ramp : f_mean;

wire signed [31:0] d_in = op16(pool_reg[di_cfg_reg[2:0]]);
wire signed [31:0] d_rst = op16(pool_reg[di_cfg_reg[6:4]]);
wire signed [31:0] d_scaled = sdiv(d_in * $signed(di_f1_reg), $signed(di_f2_reg));
wire signed [31:0] d_raw = di_cfg_reg[`DI_TYPE] ? d_scaled - $signed(di_prev_reg)
                                                : d_scaled + $signed(di_prev_reg);
wire signed [31:0] di_val = (d_rst >= 32'sh1) ? 32'sh0 :
    clamp(d_raw, di_upper_reg, di_lower_reg);
wire [15:0] tb_len = di_cfg_reg[`DI_TB_LSB +: 16];
wire tb_end = (tb_cnt_reg + 16'h1 >= tb_len);

wire signed [31:0] k_a = op16(pool_reg[cmp_cfg_reg[2:0]]);
wire signed [31:0] k_b = op16(pool_reg[cmp_cfg_reg[6:4]]);
wire [1:0] k_type = cmp_cfg_reg[`CMP_TYPE_LSB +: 2];
// Type code 3 is undefined and is treated as a failed comparison.
wire k_true = (k_type == `CMP_GT) ? (k_a > k_b) :
              (k_type == `CMP_GE) ? (k_a >= k_b) :
              (k_type == `CMP_EQ) ? (k_a == k_b) : 1'b0;
wire signed [31:0] cmp_val = k_true ? op16(pool_reg[cmp_cfg_reg[10:8]])
                                    : op16(pool_reg[cmp_cfg_reg[14:12]]);

wire calc_go = (cur_block == 2'h0) & (calc_cfg_reg[`CALC_STAGE_LSB +: 2] == cur_stage);
wire filt_go = (cur_block == 2'h1) & (filt_cfg_reg[`FILT_STAGE_LSB +: 2] == cur_stage);
wire di_go = (cur_block == 2'h2) & (di_cfg_reg[`DI_STAGE_LSB +: 2] == cur_stage);
wire cmp_go = (cur_block == 2'h3) & (cmp_cfg_reg[`CMP_STAGE_LSB +: 2] == cur_stage);

////////////////////////////////////////////////////////////////////////////////
// Cycle timer and stage sequencer.

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tick_cnt_reg <= 18'h0;
    end else if (tick) begin
        tick_cnt_reg <= 18'h0;
    end else begin
        tick_cnt_reg <= tick_cnt_reg + 18'h1;
    end
end

// Every stage visits the four block kinds in order, so a block allocated to
// a later stage sees results written earlier in the same pass.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= ST_IDLE;
        step_reg <= 4'h0;
        cycle_busy <= 1'b0;
        calc_div_zero_flag <= 1'b0;
        di_prev_reg <= 32'h0;
        tb_cnt_reg <= 16'h0;
        for (i = 0; i < 8; i = i + 1) begin
            pool_reg[i] <= 32'h0;
        end
    end else begin
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    // External inputs are frozen here for the whole pass.
                    for (i = 0; i < 4; i = i + 1) begin
                        pool_reg[i] <= {{16{in_reg[i][15]}}, in_reg[i]};
                    end
                    state_reg <= ST_RUN;
                    step_reg <= 4'h0;
                    cycle_busy <= 1'b1;
                end
            end
            ST_RUN: begin
                if (calc_go) begin
                    pool_reg[`SLOT_CALC] <= calc_val;
                    calc_div_zero_flag <= calc_zero;
                end
                if (filt_go) begin
                    pool_reg[`SLOT_FILT] <= filt_val;
                end
                if (di_go) begin
                    pool_reg[`SLOT_DI] <= di_val;
                    if (tb_end) begin
                        di_prev_reg <= d_scaled;
                        tb_cnt_reg <= 16'h0;
                    end else begin
                        tb_cnt_reg <= tb_cnt_reg + 16'h1;
                    end
                end
                if (cmp_go) begin
                    pool_reg[`SLOT_CMP] <= cmp_val;
                end
                if (step_reg == 4'hf) begin
                    state_reg <= ST_IDLE;
                    cycle_busy <= 1'b0;
                end
                step_reg <= step_reg + 4'h1;
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave: one wait-free access phase, read data latched at setup.

always @* begin
    rd_next = 32'h0;
    err_next = 1'b0;
    if (paddr[11:4] == `OFS_IN_BASE >> 4) begin
        rd_next = {16'h0, in_reg[paddr[3:2]]};
    end else if (paddr[11:5] == `OFS_POOL_BASE >> 5) begin
        rd_next = pool_reg[paddr[4:2]];
    end else if (paddr == `OFS_CTRL) begin
        rd_next = {31'h0, run_reg};
    end else if (paddr == `OFS_STATUS) begin
        rd_next = {30'h0, calc_div_zero_flag, cycle_busy};
    end else if (paddr == `OFS_CALC_CFG) begin
        rd_next = calc_cfg_reg;
    end else if (paddr == `OFS_CALC_UPPER) begin
        rd_next = calc_upper_reg;
    end else if (paddr == `OFS_CALC_LOWER) begin
        rd_next = calc_lower_reg;
    end else if (paddr == `OFS_FILT_CFG) begin
        rd_next = filt_cfg_reg;
    end else if (paddr == `OFS_FILT_PARAM) begin
        rd_next = filt_param_reg;
    end else if (paddr == `OFS_DI_CFG) begin
        rd_next = di_cfg_reg;
    end else if (paddr == `OFS_DI_F1) begin
        rd_next = di_f1_reg;
    end else if (paddr == `OFS_DI_F2) begin
        rd_next = di_f2_reg;
    end else if (paddr == `OFS_DI_UPPER) begin
        rd_next = di_upper_reg;
    end else if (paddr == `OFS_DI_LOWER) begin
        rd_next = di_lower_reg;
    end else if (paddr == `OFS_CMP_CFG) begin
        rd_next = cmp_cfg_reg;
    end else begin
        err_next = 1'b1;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= apb_setup;
        pslverr <= apb_setup & err_next;
        if (apb_setup) begin
            prdata <= pwrite ? 32'h0 : rd_next;
        end
    end
end

// Configuration changed while a pass is running takes effect at once; software
// should write it between passes when results must stay consistent.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        run_reg <= 1'b0;
        trig_reg <= 1'b0;
        for (j = 0; j < 4; j = j + 1) begin
            in_reg[j] <= 16'h0;
        end
        calc_cfg_reg <= `RST_CFG;
        calc_upper_reg <= `RST_UPPER;
        calc_lower_reg <= `RST_LOWER;
        filt_cfg_reg <= `RST_CFG;
        filt_param_reg <= `RST_ONE;
        di_cfg_reg <= `RST_CFG;
        di_f1_reg <= `RST_ONE;
        di_f2_reg <= `RST_ONE;
        di_upper_reg <= `RST_UPPER;
        di_lower_reg <= `RST_LOWER;
        cmp_cfg_reg <= `RST_CFG;
    end else begin
        if (start) begin
            trig_reg <= 1'b0;
        end
        if (apb_wr) begin
            if (paddr[11:4] == `OFS_IN_BASE >> 4) begin
                in_reg[paddr[3:2]] <= pwdata[15:0];
            end else if (paddr == `OFS_CTRL) begin
                run_reg <= pwdata[`CTRL_RUN];
                if (pwdata[`CTRL_TRIG]) begin
                    trig_reg <= 1'b1;
                end
            end else if (paddr == `OFS_CALC_CFG) begin
                calc_cfg_reg <= pwdata;
            end else if (paddr == `OFS_CALC_UPPER) begin
                calc_upper_reg <= pwdata;
            end else if (paddr == `OFS_CALC_LOWER) begin
                calc_lower_reg <= pwdata;
            end else if (paddr == `OFS_FILT_CFG) begin
                filt_cfg_reg <= pwdata;
            end else if (paddr == `OFS_FILT_PARAM) begin
                filt_param_reg <= pwdata;
            end else if (paddr == `OFS_DI_CFG) begin
                di_cfg_reg <= pwdata;
            end else if (paddr == `OFS_DI_F1) begin
                di_f1_reg <= pwdata;
            end else if (paddr == `OFS_DI_F2) begin
                di_f2_reg <= pwdata;
            end else if (paddr == `OFS_DI_UPPER) begin
                di_upper_reg <= pwdata;
            end else if (paddr == `OFS_DI_LOWER) begin
                di_lower_reg <= pwdata;
            end else if (paddr == `OFS_CMP_CFG) begin
                cmp_cfg_reg <= pwdata;
            end
        end
    end
end

endmodule // arithmetic_unit

`default_nettype wire

// ===== sim/arith_function_blocks_properties.sv
`timescale 1ns/1ps
`default_nettype none
module arith_unit_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic calc_div_zero_flag,
    input wire logic cycle_busy
);
    logic [4:0] busy_cnt_reg;
    // Counts busy cycles so the pass length can be checked without a long repetition.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_cnt_reg <= 5'h00;
        else
            busy_cnt_reg <= cycle_busy ? busy_cnt_reg + 5'h01 : 5'h00;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_pass_body;
        cycle_busy [*8] ##1 cycle_busy [*8] ##1 !cycle_busy;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_answer)
        else $error("no single ready pulse after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside an access phase");
    a_idle_no_ready: assert property (!psel |=> !pready)
        else $error("ready without a request");
    a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    a_pass_shape: assert property ($rose(cycle_busy) |-> s_pass_body)
        else $error("processing pass has wrong length");
    a_busy_length: assert property ($fell(cycle_busy) |-> busy_cnt_reg == 5'd16)
        else $error("busy count wrong at end of pass");
    a_busy_bounded: assert property (cycle_busy |-> busy_cnt_reg < 5'd16)
        else $error("pass runs too long");
    a_flag_in_pass: assert property ($changed(calc_div_zero_flag) |-> cycle_busy)
        else $error("division flag changed outside a pass");
endmodule // arith_unit_checker
bind arithmetic_unit arith_unit_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .calc_div_zero_flag(calc_div_zero_flag), .cycle_busy(cycle_busy));
`default_nettype wire

// ===== sim/arith_function_blocks_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "arith_unit_defines.vh"
module arith_function_blocks_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flag, busy, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    time t0;
    int miscompares = 0;
    int comparisons = 0;
    int ca[5] = '{100, -100, 5, 1000, -1000};
    int cm1[5] = '{7, 7, 7, 1000, 1000};
    int cm2[5] = '{3, 3, 0, 1, 1};
    int cb[5] = '{5, 5, 9, 0, 0};
    int cx[5] = '{238, -238, 0, 5000, -300};
    int fin[7] = '{0, 100, 100, 100, 100, 50, 50};
    int fpar[7] = '{1, 4, 4, 10, 10, 10, 10};
    int fx[7] = '{0, 25, 43, 53, 63, 53, 50};
    int din[4] = '{10, 20, 20, -5};
    int dx[4] = '{0, 15, 40, -37};
    arithmetic_unit #(.CYCLE_CLKS(40)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .calc_div_zero_flag(flag), .cycle_busy(busy));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits an edge first so two back-to-back calls never drive psel twice in one step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic setin(input int i, input int v);
        apb(1'b1, 12'h010 + 12'(4 * i), 32'(v));
    endtask
    task automatic run_pass();
        apb(1'b1, `OFS_CTRL, 32'h2);
        wait (busy === 1'b1);
        wait (busy === 1'b0);
    endtask
    ////////////////////////////////////////
    initial begin
        #1_000_000;
        miscompares++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk("calc upper", `OFS_CALC_UPPER, `RST_UPPER);
        rchk("di lower", `OFS_DI_LOWER, `RST_LOWER);
        rchk("di f2", `OFS_DI_F2, `RST_ONE);
        rchk("unmapped data", 12'h0f0, 32'h0);
        chk("unmapped error", 32'h1, err);
        $display("test registers done");
        apb(1'b1, `OFS_CALC_UPPER, 32'd5000);
        apb(1'b1, `OFS_CALC_LOWER, 32'hfffffed4);
        for (int i = 0; i < 5; i++) begin
            setin(0, ca[i]);
            setin(1, cm1[i]);
            setin(2, cm2[i]);
            setin(3, cb[i]);
            apb(1'b1, `OFS_CALC_CFG, {15'h0, i == 1, 16'h3210});
            run_pass();
            rchk("calc result", 12'h090, cx[i]);
            chk("div flag", i == 2, flag);
            rchk("status", `OFS_STATUS, {30'h0, i == 2, 1'b0});
        end
        $display("test calc done");
        setin(2, 11);
        setin(3, -22);
        for (int t = 0; t < 4; t++)
            for (int k = 0; k < 3; k++) begin
                setin(0, 6 - k);
                setin(1, 5);
                apb(1'b1, `OFS_CMP_CFG, 32'h3210 | (t << 16));
                run_pass();
                rchk("compare", 12'h09c, (t == 0 ? k == 0 : t == 1 ? k < 2 : t == 2 ? k == 1 : 0) ? 11 : -22);
            end
        $display("test compare done");
        for (int i = 0; i < 7; i++) begin
            setin(0, fin[i]);
            apb(1'b1, `OFS_FILT_CFG, {27'h0, i > 2, 4'h0});
            apb(1'b1, `OFS_FILT_PARAM, fpar[i]);
            run_pass();
            rchk("filter", 12'h094, fx[i]);
        end
        $display("test filter done");
        apb(1'b1, `OFS_DI_F1, 32'h3);
        apb(1'b1, `OFS_DI_F2, 32'h2);
        apb(1'b1, `OFS_DI_UPPER, 32'd40);
        for (int i = 0; i < 4; i++) begin
            setin(0, din[i]);
            setin(1, i == 0);
            apb(1'b1, `OFS_DI_CFG, {16'h1, 7'h0, i != 2, 8'h10});
            run_pass();
            rchk("integ diff", 12'h098, dx[i]);
        end
        $display("test integ diff done");
        setin(1, 1);
        setin(2, 77);
        setin(3, 0);
        // Compare after calc sees the fresh value; compare before calc sees last pass.
        for (int i = 0; i < 2; i++) begin
            setin(0, 300 + i);
            apb(1'b1, `OFS_CALC_CFG, 32'h0020_3110);
            apb(1'b1, `OFS_CMP_CFG, 32'h0012_2104 | ((1 - i) << 21));
            run_pass();
            rchk("stage order", 12'h09c, i ? 77 : 1);
        end
        $display("test stages done");
        // Periodic mode: passes start on the divider tick, 40 clocks of 100 ns apart.
        apb(1'b1, `OFS_CTRL, 32'h1);
        rchk("run bit on", `OFS_CTRL, 32'h1);
        @(posedge busy);
        t0 = $time;
        @(posedge busy);
        chk("pass period", 32'd4000, 32'($time - t0));
        apb(1'b1, `OFS_CTRL, 32'h0);
        rchk("run bit off", `OFS_CTRL, 32'h0);
        $display("test periodic done");
        tally_and_finish();
    end
endmodule // arith_function_blocks_bench
`default_nettype wire
